// ---- adcctl_asserts.sv ----
// Purpose: port-level checks of the converter control block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the testbench top file
`timescale 1ns/1ns
module adcctl_asserts
(
    input wire        CLK_I,
    input wire        RST_B_I,
    input wire        S_AXI_AWVALID_I,
    input wire        S_AXI_AWREADY_O,
    input wire        S_AXI_WVALID_I,
    input wire        S_AXI_WREADY_O,
    input wire        S_AXI_BVALID_O,
    input wire        S_AXI_ARVALID_I,
    input wire        S_AXI_ARREADY_O,
    input wire        S_AXI_RVALID_O,
    input wire        EXT_SYSCLK_I,
    input wire [5:0]  CHANNEL_SEL_O,
    input wire        CHANNEL_VALID_O,
    input wire [1:0]  REF_SEL_O,
    input wire        CONVERTER_ENABLE_O,
    input wire        SAMPLE_O
);
    reg [1:0] up;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // settle count: outputs lag the reset release, so skip those edges
    always @(posedge CLK_I)
        if (!RST_B_I)
            up <= 2'd0;
        else if (up != 2'd3)
            up <= up + 2'd1;
    // channel code held long enough for the valid flag to follow
    sequence s_set;
        (up == 2'd3 && $stable(CHANNEL_SEL_O))[*2];
    endsequence
    sequence s_wr;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    endsequence
    property p_int;
        s_set ##0 (CHANNEL_SEL_O >= 6'h3b) |-> CHANNEL_VALID_O;
    endproperty
    a_int: assert property (p_int) else $error("internal channel not connected");
    property p_port;
        s_set ##0 ((CHANNEL_SEL_O >= 6'h10 && CHANNEL_SEL_O <= 6'h17)
            || (CHANNEL_SEL_O >= 6'h0c && CHANNEL_SEL_O <= 6'h0f)
            || CHANNEL_SEL_O <= 6'h03) |-> CHANNEL_VALID_O;
    endproperty
    a_port: assert property (p_port) else $error("port channel not connected");
    property p_rsv;
        s_set ##0 (CHANNEL_SEL_O >= 6'h08 && CHANNEL_SEL_O <= 6'h0b) |-> !CHANNEL_VALID_O;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved channel connected");
    property p_ext;
        (up == 2'd3 && EXT_SYSCLK_I && $stable(CHANNEL_SEL_O))[*6]
            ##0 (CHANNEL_SEL_O == 6'h04 || CHANNEL_SEL_O == 6'h05) |-> !CHANNEL_VALID_O;
    endproperty
    a_ext: assert property (p_ext) else $error("pin 4/5 analog under ext clock");
    property p_ref;
        REF_SEL_O != 2'b01;
    endproperty
    a_ref: assert property (p_ref) else $error("reserved reference code driven");
    property p_samp;
        SAMPLE_O |-> CONVERTER_ENABLE_O;
    endproperty
    a_samp: assert property (p_samp) else $error("sampling while disabled");
    property p_wlat;
        s_wr |-> ##[1:2] S_AXI_BVALID_O;
    endproperty
    a_wlat: assert property (p_wlat) else $error("write response late");
    property p_rlat;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
    endproperty
    a_rlat: assert property (p_rlat) else $error("read data late");
    property p_bref;
        S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O;
    endproperty
    a_bref: assert property (p_bref) else $error("write taken while response pending");
    property p_rref;
        S_AXI_RVALID_O |-> !S_AXI_ARREADY_O;
    endproperty
    a_rref: assert property (p_rref) else $error("read taken while data pending");
endmodule

// ---- adcctl_regs.vh ----
// What this block does
// - channel codes 111111..111011 route reference buffers, dac, temp sensor, ground
// - codes 010111..010000 port c, 001111..001100 port b, 000101..000000 port a
// - codes 001011..001000 are reserved and connect no channel
// - writing one to the status bit starts a conversion; reads one meanwhile
// - hardware clears the status bit when the conversion completes
// - enable bit turns the converter on; zero means disabled, no current
// - port a pins 4 and 5 analog off when external system clock
// - right justified format forces six upper high-result bits to zero
// - left justified format forces six lower low-result bits to zero
// - clock field picks sysclk/2,/8,/32,/4,/16,/64 or rc clock for 011,111
// - reference field: 00 supply, 10 external pin, 11 fixed reference, 01 reserved
// - control one bits 3-2 and trigger select bits 7-5 read zero
// - trigger field picks auto source, detected on rising edge only
// - left justified high result holds result bits 9 to 2
// - left justified low result bits 7-6 hold result bits 1-0
// - right justified high result bits 1-0 hold result bits 9-8
// - right justified low result holds result bits 7 to 0
// - rising edge of selected trigger sets the status bit, starting conversion
// - trigger value 0 disables; 0x13 and above reserved
//
// Purpose: register offsets, fields and reset values of the converter control
// Assumes: 32-bit axi4-lite words, 8-bit registers in the low byte
// Notes:   definitions only
`ifndef ADCCTL_REGS_VH
`define ADCCTL_REGS_VH
`define ADCCTL_OFS_CTRL0    4'h0
`define ADCCTL_OFS_CTRL1    4'h1
`define ADCCTL_OFS_TRIG     4'h2
`define ADCCTL_OFS_RES_HI   4'h3
`define ADCCTL_OFS_RES_LO   4'h4
`define ADCCTL_RST_CTRL0    8'h00
`define ADCCTL_RST_CTRL1    8'h00
`define ADCCTL_RST_TRIG     8'h00
`define ADCCTL_BIT_ENABLE   0
`define ADCCTL_BIT_GO       1
`define ADCCTL_CHS_LSB      2
`define ADCCTL_BIT_FMT      7
`define ADCCTL_CS_LSB       4
`define ADCCTL_TRIG_MAX     5'h12
`define ADCCTL_CH_VSS       6'h3b
`define ADCCTL_CH_RSV_LO    6'h08
`define ADCCTL_CH_RSV_HI    6'h0b
`define ADCCTL_CH_RA4       6'h04
`define ADCCTL_CH_RA5       6'h05
`define ADCCTL_CONV_CYCLES  8'd11
`define ADCCTL_RC_DIV       8'd50
`endif

// ---- adcctl_tb.sv ----
// Purpose: self-checking bench of the converter control registers
// Assumes: byte addresses 0x00..0x10, short conversions via parameters
// Notes:   expected results wait in queues until the monitor sees them
`timescale 1ns/1ns
module testbench;
    localparam CC = 3;
    localparam RC = 6;
    reg         clk = 1'b0;
    reg         rst_b = 1'b0;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg         ext = 1'b0;
    reg  [11:0] awaddr = 12'h000, araddr = 12'h000;
    reg  [31:0] wdata = 32'h0, last_rd;
    reg  [18:0] trig = 19'h0;
    reg  [9:0]  data = 10'h000;
    wire        awready, wready, bvalid, arready, rvalid, chvld, enab, clken, samp;
    wire [1:0]  bresp, rresp, refsel;
    wire [31:0] rdata;
    wire [5:0]  chsel;
    integer     miscompares = 0, checked = 0, seed = 70, nsample = 0, cnt = 0, gap = 0, i, k;
    integer     dvt [8] = '{2, 8, 32, RC, 4, 16, 64, RC};
    reg  [33:0] rq [$];
    reg  [31:0] mq [$];
    reg  [1:0]  bq [$];
    // clock at 100 MHz
    always #5 clk = ~clk;
    adcctl_top #(.CONV_CYCLES(CC), .RC_DIV(RC)) adcctl_top_i (.CLK_I(clk), .RST_B_I(rst_b),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .TRIG_SRC_I(trig),
        .EXT_SYSCLK_I(ext), .ADC_DATA_I(data), .CHANNEL_SEL_O(chsel),
        .CHANNEL_VALID_O(chvld), .REF_SEL_O(refsel), .CONVERTER_ENABLE_O(enab),
        .CONV_CLK_EN_O(clken), .SAMPLE_O(samp));
    task chk(input [8*5:1] nm, input [33:0] e, input [33:0] g);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("BAD %0s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task report_and_stop;
    begin
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    task tmo;
    begin
        miscompares = miscompares + 1;
        report_and_stop;
    end
    endtask
    // negedge sampling predicts the next edge's handshake without races
    always @(negedge clk)
    begin
        if (bvalid && bready)
            chk("bresp", bq.pop_front(), bresp);
        if (rvalid && rready)
        begin
            last_rd = rdata;
            chk("rdata", rq.pop_front(), {rresp, rdata & mq.pop_front()});
        end
        nsample = nsample + samp;
        gap = clken ? cnt : gap;
        cnt = clken ? 1 : cnt + 1;
    end
    task wr(input [11:0] a, input [7:0] d, input [1:0] er);
        reg     ta, tw, tb;
        integer n;
    begin
        @(posedge clk);
        bq.push_back(er);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        for (n = 0; n < 100 && !tb; n = n + 1)
        begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            if (tb)
                bready <= 1'b0;
        end
        if (!tb)
            tmo;
    end
    endtask
    task rd(input [11:0] a, input [7:0] e, input [31:0] m, input [1:0] er);
        reg     ta, tr;
        integer n;
    begin
        @(posedge clk);
        rq.push_back({er, 24'h0, e & m[7:0]});
        mq.push_back(m);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        for (n = 0; n < 100 && !tr; n = n + 1)
        begin
            @(negedge clk);
            ta = arvalid && arready;
            tr = rvalid;
            @(posedge clk);
            if (ta)
                arvalid <= 1'b0;
            if (tr)
                rready <= 1'b0;
        end
        if (!tr)
            tmo;
    end
    endtask
    // poll the status bit until hardware clears it
    task waitdone;
        integer n;
    begin
        last_rd = 32'h2;
        for (n = 0; n < 200 && last_rd[1]; n = n + 1)
            rd(12'h000, 8'h00, 32'h0, 2'b00);
        if (last_rd[1])
            tmo;
    end
    endtask
    function chan_ok(input [5:0] c, input x);
        chan_ok = c >= 6'h3b || (c >= 6'h10 && c <= 6'h17) || (c >= 6'h0c && c <= 6'h0f)
            || c <= 6'h03 || ((c == 6'h04 || c == 6'h05) && !x);
    endfunction
    // main sequence: reset, registers, channels, conversions, triggers
    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        for (i = 0; i < 3; i = i + 1)
            rd(12'(4 * i), 8'h00, 32'hffffffff, 2'b00);
        wr(12'h004, 8'hff, 2'b00);
        rd(12'h004, 8'hf3, 32'hffffffff, 2'b00);
        wr(12'h008, 8'hff, 2'b00);
        rd(12'h008, 8'h1f, 32'hffffffff, 2'b00);
        wr(12'h014, 8'h55, 2'b10);
        rd(12'h014, 8'h00, 32'h0, 2'b10);
        $display("test registers done");
        for (k = 0; k < 2; k = k + 1)
        begin
            ext <= k[0];
            for (i = 0; i < 64; i = i + 1)
            begin
                wr(12'h000, {i[5:0], 2'b00}, 2'b00);
                rd(12'h000, {i[5:0], 2'b00}, 32'hffffffff, 2'b00);
                @(negedge clk);
                chk("chsel", i[5:0], chsel);
                chk("chvld", chan_ok(i[5:0], k[0]), chvld);
            end
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(12'h004, {6'h00, i[1:0]}, 2'b00);
            @(negedge clk);
            chk("ref", (i == 1) ? 2'b00 : i[1:0], refsel);
        end
        $display("test channels done");
        k = nsample;
        wr(12'h000, 8'h02, 2'b00);
        rd(12'h000, 8'h00, 32'hffffffff, 2'b00);
        chk("samp", k, nsample);
        wr(12'h000, 8'h01, 2'b00);
        for (i = 0; i < 8; i = i + 1)
        begin
            data <= 10'($random(seed));
            wr(12'h004, {i[0], i[2:0], 4'h0}, 2'b00);
            wr(12'h00c, 8'hff, 2'b00);
            wr(12'h010, 8'hff, 2'b00);
            wr(12'h000, 8'h03, 2'b00);
            if (dvt[i] >= 8)
                rd(12'h000, 8'h03, 32'hffffffff, 2'b00);
            waitdone;
            chk("gap", dvt[i], gap);
            chk("enab", 1'b1, enab);
            rd(12'h00c, i[0] ? {6'h00, data[9:8]} : data[9:2], 32'hffffffff, 2'b00);
            rd(12'h010, i[0] ? data[7:0] : {data[1:0], 6'h00}, 32'hffffffff, 2'b00);
        end
        $display("test conversions done");
        wr(12'h004, 8'h00, 2'b00);
        // code 0x13 is reserved: its would-be source rises but must start nothing
        for (i = 0; i < 20; i = i + 1)
        begin
            wr(12'h008, i[7:0], 2'b00);
            k = nsample;
            trig <= ~(19'h1 << (i - 1));
            repeat (10) @(posedge clk);
            chk("auto", k, nsample);
            trig <= {19{1'b1}};
            repeat (10) @(posedge clk);
            chk("auto", k + (i > 0 && i < 19), nsample);
            repeat (10) @(posedge clk);
            chk("auto", k + (i > 0 && i < 19), nsample);
            trig <= 19'h0;
            repeat (10) @(posedge clk);
            chk("auto", k + (i > 0 && i < 19), nsample);
            waitdone;
        end
        wr(12'h000, 8'h00, 2'b00);
        @(negedge clk);
        chk("enab", 1'b0, enab);
        $display("test triggers done");
        report_and_stop;
    end
endmodule
bind adcctl_top adcctl_asserts adcctl_asserts_i (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
    .EXT_SYSCLK_I(EXT_SYSCLK_I), .CHANNEL_SEL_O(CHANNEL_SEL_O),
    .CHANNEL_VALID_O(CHANNEL_VALID_O), .REF_SEL_O(REF_SEL_O),
    .CONVERTER_ENABLE_O(CONVERTER_ENABLE_O), .SAMPLE_O(SAMPLE_O));

// ---- adcctl_top.v ----
// Purpose: register control of a 10-bit successive-approximation converter
// Assumes: analog core returns a 10-bit value after a fixed number of bit times
// Notes:   core is modelled by a bit-time counter; value comes from ADC_DATA_I
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "adcctl_regs.vh"
module adcctl_top
#(
    parameter CONV_CYCLES = 11,
    parameter RC_DIV      = 50
)
(
    input  wire        CLK_I,
    input  wire        RST_B_I,
    input  wire [11:0] S_AXI_AWADDR_I,
    input  wire        S_AXI_AWVALID_I,
    output wire        S_AXI_AWREADY_O,
    input  wire [31:0] S_AXI_WDATA_I,
    input  wire [3:0]  S_AXI_WSTRB_I,
    input  wire        S_AXI_WVALID_I,
    output wire        S_AXI_WREADY_O,
    output reg  [1:0]  S_AXI_BRESP_O,
    output reg         S_AXI_BVALID_O,
    input  wire        S_AXI_BREADY_I,
    input  wire [11:0] S_AXI_ARADDR_I,
    input  wire        S_AXI_ARVALID_I,
    output wire        S_AXI_ARREADY_O,
    output reg  [31:0] S_AXI_RDATA_O,
    output reg  [1:0]  S_AXI_RRESP_O,
    output reg         S_AXI_RVALID_O,
    input  wire        S_AXI_RREADY_I,
    input  wire [18:0] TRIG_SRC_I,
    input  wire        EXT_SYSCLK_I,
    input  wire [9:0]  ADC_DATA_I,
    output reg  [5:0]  CHANNEL_SEL_O,
    output reg         CHANNEL_VALID_O,
    output reg  [1:0]  REF_SEL_O,
    output reg         CONVERTER_ENABLE_O,
    output reg         CONV_CLK_EN_O,
    output reg         SAMPLE_O
);

    // software registers
    reg [5:0] channel_select;
    reg       converter_enable;
    reg       conv_go;
    reg       result_format;
    reg [2:0] conversion_clock_select;
    reg [1:0] positive_reference_select;
    reg [4:0] trigger_source_select;
    reg [7:0] result_high;
    reg [7:0] result_low;
    // axi holding state
    reg        aw_held;
    reg        w_held;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    // conversion engine
    reg [7:0] div_cnt;
    reg [7:0] bit_cnt;
    reg [18:0] trig_s1;
    reg [18:0] trig_s2;
    reg        ext_s1;
    reg        ext_s2;
    reg        sel_now;
    reg        sel_prev;
    reg [7:0]  div_target;
    reg [7:0]  rd_byte;
    wire       wr_fire;
    wire       wr_go;
    wire       trig_rise;
    wire       conv_done;
    wire [3:0] wr_idx;
    wire [3:0] rd_idx;
    // reset images, sliced per field so no field is cut or padded
    localparam [7:0] rst_ctrl0 = `ADCCTL_RST_CTRL0;
    localparam [7:0] rst_ctrl1 = `ADCCTL_RST_CTRL1;
    localparam [7:0] rst_trig  = `ADCCTL_RST_TRIG;

    assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
    assign S_AXI_WREADY_O  = !w_held && !S_AXI_BVALID_O;
    assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
    assign wr_fire = aw_held && w_held && !S_AXI_BVALID_O;
    assign wr_idx  = aw_addr[5:2];
    assign rd_idx  = S_AXI_ARADDR_I[5:2];
    // a write of one to the status bit starts a conversion
    assign wr_go = wr_fire && (wr_idx == `ADCCTL_OFS_CTRL0) && w_strb[0]
                   && (aw_addr[11:6] == 6'h00) && w_data[`ADCCTL_BIT_GO];

    // pins and trigger sources come from other domains: two flops first
    always @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            trig_s1  <= 19'h00000;
            trig_s2  <= 19'h00000;
            ext_s1   <= 1'b0;
            ext_s2   <= 1'b0;
            sel_prev <= 1'b0;
        end
        else
        begin
            trig_s1  <= TRIG_SRC_I;
            trig_s2  <= trig_s1;
            ext_s1   <= EXT_SYSCLK_I;
            ext_s2   <= ext_s1;
            sel_prev <= sel_now;
        end
    end

    // trigger mux; codes 0 and reserved select nothing
    always @*
    begin
        sel_now = 1'b0;
        if (trigger_source_select != 5'h00 && trigger_source_select <= `ADCCTL_TRIG_MAX)
            sel_now = trig_s2[trigger_source_select - 5'h01];
    end
    assign trig_rise = sel_now && !sel_prev;

    // conversion clock divider target
    always @*
    begin
        case (conversion_clock_select)
            3'b000:  div_target = 8'd2;
            3'b001:  div_target = 8'd8;
            3'b010:  div_target = 8'd32;
            3'b100:  div_target = 8'd4;
            3'b101:  div_target = 8'd16;
            3'b110:  div_target = 8'd64;
            default: div_target = RC_DIV[7:0];
        endcase
    end

    // one bit time per divider wrap; counts only while converting
    always @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            div_cnt       <= 8'h00;
            CONV_CLK_EN_O <= 1'b0;
        end
        else if (!conv_go)
        begin
            div_cnt       <= 8'h00;
            CONV_CLK_EN_O <= 1'b0;
        end
        else if (div_cnt >= div_target - 8'd1)
        begin
            div_cnt       <= 8'h00;
            CONV_CLK_EN_O <= 1'b1;
        end
        else
        begin
            div_cnt       <= div_cnt + 8'd1;
            CONV_CLK_EN_O <= 1'b0;
        end
    end

    assign conv_done = conv_go && CONV_CLK_EN_O && (bit_cnt == CONV_CYCLES[7:0] - 8'd1);

    // bit counter; sample pulse on the first bit time
    always @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            bit_cnt  <= 8'h00;
            SAMPLE_O <= 1'b0;
        end
        else
        begin
            SAMPLE_O <= conv_go && CONV_CLK_EN_O && (bit_cnt == 8'h00);
            if (!conv_go || conv_done)
                bit_cnt <= 8'h00;
            else if (CONV_CLK_EN_O)
                bit_cnt <= bit_cnt + 8'd1;
        end
    end

    // axi write address and data, taken in either order
    always @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            aw_addr        <= 12'h000;
            w_data         <= 32'h00000000;
            w_strb         <= 4'h0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= 2'b00;
        end
        else
        begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
            begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O)
            begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA_I;
                w_strb <= S_AXI_WSTRB_I;
            end
            if (wr_fire)
            begin
                aw_held        <= 1'b0;
                w_held         <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                // unmapped addresses answer slverr
                S_AXI_BRESP_O  <= (aw_addr[11:6] != 6'h00 || wr_idx > `ADCCTL_OFS_RES_LO)
                                  ? 2'b10 : 2'b00;
            end
            else if (S_AXI_BVALID_O && S_AXI_BREADY_I)
                S_AXI_BVALID_O <= 1'b0;
        end
    end

    // control registers and the status bit
    always @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            channel_select            <= rst_ctrl0[7:2];
            converter_enable          <= rst_ctrl0[`ADCCTL_BIT_ENABLE];
            conv_go                   <= rst_ctrl0[`ADCCTL_BIT_GO];
            result_format             <= rst_ctrl1[`ADCCTL_BIT_FMT];
            conversion_clock_select   <= rst_ctrl1[6:4];
            positive_reference_select <= rst_ctrl1[1:0];
            trigger_source_select     <= rst_trig[4:0];
            result_high               <= 8'h00;
            result_low                <= 8'h00;
        end
        else
        begin
            if (wr_fire && w_strb[0] && aw_addr[11:6] == 6'h00)
            begin
                case (wr_idx)
                    `ADCCTL_OFS_CTRL0:
                    begin
                        channel_select   <= w_data[7:2];
                        converter_enable <= w_data[`ADCCTL_BIT_ENABLE];
                    end
                    `ADCCTL_OFS_CTRL1:
                    begin
                        result_format             <= w_data[`ADCCTL_BIT_FMT];
                        conversion_clock_select   <= w_data[6:4];
                        positive_reference_select <= w_data[1:0];
                    end
                    `ADCCTL_OFS_TRIG:   trigger_source_select <= w_data[4:0];
                    `ADCCTL_OFS_RES_HI: result_high <= w_data[7:0];
                    `ADCCTL_OFS_RES_LO: result_low  <= w_data[7:0];
                    default:            result_low  <= result_low;
                endcase
            end
            // hardware clear; start wins over clear in the same cycle
            if (conv_done)
                conv_go <= 1'b0;
            // software start, trigger start; needs the converter on
            if ((wr_go || trig_rise) && converter_enable)
                conv_go <= 1'b1;
            if (conv_done)
            begin
                if (result_format)
                begin
                    result_high <= {6'h00, ADC_DATA_I[9:8]};
                    result_low  <= ADC_DATA_I[7:0];
                end
                else
                begin
                    result_high <= ADC_DATA_I[9:2];
                    result_low  <= {ADC_DATA_I[1:0], 6'h00};
                end
            end
        end
    end

    // analog side controls
    always @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            CHANNEL_SEL_O      <= 6'h00;
            CHANNEL_VALID_O    <= 1'b0;
            REF_SEL_O          <= 2'b00;
            CONVERTER_ENABLE_O <= 1'b0;
        end
        else
        begin
            CHANNEL_SEL_O <= channel_select;
            CHANNEL_VALID_O <= (channel_select >= `ADCCTL_CH_VSS)
                || (channel_select >= 6'h0c && channel_select <= 6'h17)
                || (channel_select <= `ADCCTL_CH_RA5
                    // external clock kills pins 4 and 5
                    && !(ext_s2 && (channel_select == `ADCCTL_CH_RA4
                                    || channel_select == `ADCCTL_CH_RA5)));
            // reserved code falls back to supply
            REF_SEL_O <= (positive_reference_select == 2'b01) ? 2'b00
                         : positive_reference_select;
            CONVERTER_ENABLE_O <= converter_enable;
        end
    end

    // read mux
    always @*
    begin
        case (rd_idx)
            `ADCCTL_OFS_CTRL0:  rd_byte = {channel_select, conv_go, converter_enable};
            `ADCCTL_OFS_CTRL1:  rd_byte = {result_format, conversion_clock_select, 2'b00,
                                           positive_reference_select};
            `ADCCTL_OFS_TRIG:   rd_byte = {3'b000, trigger_source_select};
            `ADCCTL_OFS_RES_HI: rd_byte = result_high;
            `ADCCTL_OFS_RES_LO: rd_byte = result_low;
            default:            rd_byte = 8'h00;
        endcase
    end

    // read channel: answer one cycle after address is taken
    always @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O  <= 32'h00000000;
            S_AXI_RRESP_O  <= 2'b00;
        end
        else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
        begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O  <= {24'h000000, rd_byte};
            S_AXI_RRESP_O  <= (S_AXI_ARADDR_I[11:6] != 6'h00 || rd_idx > `ADCCTL_OFS_RES_LO)
                              ? 2'b10 : 2'b00;
        end
        else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
            S_AXI_RVALID_O <= 1'b0;
    end

endmodule
